// [pqe_desc_view.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Splits one 16-byte little-endian descriptor into its fields
// ----------------------------------------------------------------
module pqe_desc_view import pqe_pkg::*; (
  input  wire logic [127:0] raw,
  input  wire logic         exp_wrap,
  output logic      [63:0]  d_addr,
  output logic      [31:0]  d_len,
  output logic      [15:0]  d_id,
  output logic              d_chain,
  output logic              d_writable,
  output logic              d_indirect,
  output logic              d_offered
);
  logic [15:0] flags;

  // Field lanes: address, length, identifier, flags
  assign d_addr     = raw[63:0];
  assign d_len      = raw[95:64];
  assign d_id       = raw[111:96];
  assign flags      = raw[127:112];
  assign d_chain    = |(flags & F_CHAIN);
  assign d_writable = |(flags & F_WRITABLE);
  assign d_indirect = |(flags & F_INDIRECT);

  // A zeroed entry never matches: offered bit must equal the wrap, consumed bit the opposite
  assign d_offered = (|(flags & F_OFFERED) == exp_wrap) && (|(flags & F_CONSUMED) != exp_wrap);
endmodule // pqe_desc_view

// [pqe_engine.sv]
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - Descriptors are started strictly in ring order.
// - Used descriptors are written in completion order.
// - Ring entries are 16-byte aligned; suppression words 4-byte aligned.
// - Entry holds 64-bit address, 32-bit length, 16-bit id, 16-bit flags.
// - Ring starts zeroed; zero entry is never treated as offered.
// - Suppression: 15-bit position, wrap bit, 2-bit policy, reserved zeros.
// - Policy 0 enables, 1 disables, 2 enables at one position.
// - Flag value 1 means the list continues in the next entry.
// - Flag value 4 means the buffer holds a descriptor table.
// - Never write device-readable buffers; avoid reading writable ones.
// - Consume only entries whose offered bit changed.
// - No change to an entry after its consumed bit flipped.
// - Chained entries are consumed in order; list length may be capped.
// - Wrap counters start at 1 and toggle at ring end.
// - Device may fetch an entry as soon as it is offered.
module pqe_engine import pqe_pkg::*; (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  output logic              mem_req,
  output logic              mem_we,
  output logic      [63:0]  mem_addr,
  output logic      [127:0] mem_wdata,
  input  wire logic         mem_ack,
  input  wire logic [127:0] mem_rdata,
  output logic              buf_valid,
  input  wire logic         buf_ready,
  output logic      [63:0]  buf_addr,
  output logic      [31:0]  buf_len,
  output logic              buf_writable,
  output logic              buf_last,
  input  wire logic         cmp_valid,
  output logic              cmp_ready,
  input  wire logic [31:0]  cmp_len,
  output logic              used_notify
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pqe_state_e   state_ff, nxt_state;
  logic         ctrl_en_ff;
  logic [14:0]  qsize_ff;
  logic [63:0]  ring_base_ff, devt_base_ff;
  logic [15:0]  maxch_ff, hint_ff;
  logic         err_ff;
  logic [31:0]  count_ff;
  logic [31:0]  prdata_ff;
  logic [14:0]  pos_ff, nxt_pos, head_ff, nxt_head;
  logic         wrap_ff, nxt_wrap, uwrap_ff, nxt_uwrap;
  logic [127:0] raw_ff;
  logic         in_tbl_ff, nxt_in_tbl;
  logic [63:0]  tbl_base_ff, nxt_tbl_base;
  logic [15:0]  tbl_idx_ff, nxt_tbl_idx, tbl_left_ff, nxt_tbl_left;
  logic [15:0]  nbuf_ff, nxt_nbuf, id_ff, nxt_id;
  logic [63:0]  buf_addr_ff, nxt_buf_addr;
  logic [31:0]  buf_len_ff, nxt_buf_len, used_len_ff, nxt_used_len;
  logic         buf_wr_ff, nxt_buf_wr, more_ff, nxt_more;
  logic         any_wr_ff, nxt_any_wr, notify_ff, nxt_notify;
  logic         err_set, count_inc;

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  logic        apb_hit, apb_wr, apb_setup, qrst, err_clr;
  logic [31:0] rd_val;
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite && apb_hit;
  assign qrst      = apb_wr && (paddr == OFF_CTRL) && pwdata[CTRL_QRST_BIT];
  assign err_clr   = apb_wr && (paddr == OFF_STATUS) && pwdata[ST_ERR_BIT];
  assign pready    = 1'b1;   // Every access finishes in its first access cycle
  assign pslverr   = psel && penable && !apb_hit;
  assign prdata    = prdata_ff;

  // Read mux; unmapped offsets read zero and answer with an error
  always_comb begin
    apb_hit = 1'b1;
    if (paddr == OFF_CTRL)         rd_val = {31'h0, ctrl_en_ff};
    else if (paddr == OFF_QSIZE)   rd_val = {17'h0, qsize_ff};
    else if (paddr == OFF_RING_LO) rd_val = ring_base_ff[31:0];
    else if (paddr == OFF_RING_HI) rd_val = ring_base_ff[63:32];
    else if (paddr == OFF_DEVT_LO) rd_val = devt_base_ff[31:0];
    else if (paddr == OFF_DEVT_HI) rd_val = devt_base_ff[63:32];
    else if (paddr == OFF_MAXCH)   rd_val = {16'h0, maxch_ff};
    else if (paddr == OFF_NOTIFY)  rd_val = {16'h0, hint_ff};
    else if (paddr == OFF_STATUS)  rd_val = {13'h0, uwrap_ff, err_ff, state_ff != S_IDLE, wrap_ff, pos_ff};
    else if (paddr == OFF_COUNT)   rd_val = count_ff;
    else begin
      apb_hit = 1'b0;
      rd_val  = 32'h0;
    end
  end

  // Software registers; alignment of the bases is the driver's duty, low bits are dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_en_ff   <= 1'b0;
      qsize_ff     <= QSIZE_RST;
      ring_base_ff <= 64'h0;
      devt_base_ff <= 64'h0;
      maxch_ff     <= MAXCH_RST;
      hint_ff      <= 16'h0;
      prdata_ff    <= 32'h0;
    end else begin
      if (apb_setup) prdata_ff <= rd_val;
      if (apb_wr && paddr == OFF_CTRL)    ctrl_en_ff <= pwdata[CTRL_EN_BIT];
      if (apb_wr && paddr == OFF_QSIZE)   qsize_ff <= pwdata[14:0];
      if (apb_wr && paddr == OFF_RING_LO) ring_base_ff[31:0] <= {pwdata[31:DESC_SHIFT], 4'h0};
      if (apb_wr && paddr == OFF_RING_HI) ring_base_ff[63:32] <= pwdata;
      if (apb_wr && paddr == OFF_DEVT_LO) devt_base_ff[31:0] <= {pwdata[31:EVT_SHIFT], 2'h0};
      if (apb_wr && paddr == OFF_DEVT_HI) devt_base_ff[63:32] <= pwdata;
      if (apb_wr && paddr == OFF_MAXCH)   maxch_ff <= pwdata[15:0];
      if (apb_wr && paddr == OFF_NOTIFY)  hint_ff <= pwdata[15:0]; // Position and wrap of next unoffered
    end
  end

  // ----------------------------------------------------------------
  // Descriptor view and helpers
  // ----------------------------------------------------------------
  logic [63:0] v_addr;
  logic [31:0] v_len;
  logic [15:0] v_id;
  logic        v_chain, v_wr, v_ind, v_offered;

  pqe_desc_view u_view (
    .raw        (raw_ff),
    .exp_wrap   (wrap_ff),
    .d_addr     (v_addr),
    .d_len      (v_len),
    .d_id       (v_id),
    .d_chain    (v_chain),
    .d_writable (v_wr),
    .d_indirect (v_ind),
    .d_offered  (v_offered)
  );

  // Byte address of a ring entry; used for fetch and for write-back
  function automatic logic [63:0] ring_addr(input logic [63:0] base, input logic [14:0] idx);
    ring_addr = base + {45'h0, idx, 4'h0};
  endfunction

  logic [15:0] limit;
  logic        last_slot, rd_done;
  logic [31:0] evt_word;
  logic        notify_hit;
  logic [15:0] wb_flags;
  // Zero cap means the queue size bounds a list
  assign limit     = (maxch_ff == 16'h0) ? {1'b0, qsize_ff} : maxch_ff;
  assign last_slot = (pos_ff == qsize_ff - 15'h1);
  assign rd_done   = mem_ack && (state_ff == S_RING_RD || state_ff == S_TBL_RD);
  // Pick the 32-bit suppression word out of its 16-byte line
  assign evt_word  = mem_rdata[{devt_base_ff[3:2], 5'h0} +: 32];
  assign notify_hit = (evt_word[17:16] == EVT_ENABLE) ||
                      (evt_word[17:16] == EVT_DESC && evt_word[14:0] == head_ff && evt_word[15] == uwrap_ff);
  assign wb_flags  = uwrap_ff ? (F_OFFERED | F_CONSUMED) : 16'h0;

  // ----------------------------------------------------------------
  // Memory and user-side outputs
  // ----------------------------------------------------------------
  assign mem_req   = (state_ff == S_RING_RD) || (state_ff == S_TBL_RD) || (state_ff == S_WB) || (state_ff == S_EVT_RD);
  assign mem_we    = (state_ff == S_WB);
  assign mem_addr  = (state_ff == S_RING_RD) ? ring_addr(ring_base_ff, pos_ff) :
                     (state_ff == S_TBL_RD)  ? tbl_base_ff + {44'h0, tbl_idx_ff, 4'h0} :
                     (state_ff == S_WB)      ? ring_addr(ring_base_ff, head_ff) :
                                               {devt_base_ff[63:4], 4'h0};
  // One 16-byte write carries the flags, so the entry is touched once only
  assign mem_wdata = {wb_flags, id_ff, used_len_ff, 64'h0};
  assign buf_valid    = (state_ff == S_ISSUE);
  assign buf_addr     = buf_addr_ff;
  assign buf_len      = buf_len_ff;
  assign buf_writable = buf_wr_ff; // User may write only when set, and should not read it then
  assign buf_last     = !more_ff;
  assign cmp_ready    = (state_ff == S_WAIT_CMP);
  assign used_notify  = notify_ff;

  // ----------------------------------------------------------------
  // Ring walker
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state    = state_ff;
    nxt_pos      = pos_ff;
    nxt_wrap     = wrap_ff;
    nxt_head     = head_ff;
    nxt_uwrap    = uwrap_ff;
    nxt_in_tbl   = in_tbl_ff;
    nxt_tbl_base = tbl_base_ff;
    nxt_tbl_idx  = tbl_idx_ff;
    nxt_tbl_left = tbl_left_ff;
    nxt_nbuf     = nbuf_ff;
    nxt_id       = id_ff;
    nxt_buf_addr = buf_addr_ff;
    nxt_buf_len  = buf_len_ff;
    nxt_buf_wr   = buf_wr_ff;
    nxt_more     = more_ff;
    nxt_any_wr   = any_wr_ff;
    nxt_used_len = used_len_ff;
    nxt_notify   = 1'b0;
    err_set      = 1'b0;
    count_inc    = 1'b0;
    case (state_ff)
      S_IDLE: begin
        if (ctrl_en_ff) nxt_state = S_RING_RD; // Poll the next slot; entries are fetched once offered
      end
      S_RING_RD, S_TBL_RD: begin
        if (mem_ack) nxt_state = S_CHECK;
      end
      S_CHECK: begin
        if (in_tbl_ff) begin
          // Table entries: only the writable flag counts, id is ignored
          if (nbuf_ff >= limit) begin
            err_set   = 1'b1;
            nxt_state = S_HALT;
          end else begin
            nxt_buf_addr = v_addr;
            nxt_buf_len  = v_len;
            nxt_buf_wr   = v_wr;
            nxt_more     = (tbl_left_ff != 16'h1);
            nxt_tbl_left = tbl_left_ff - 16'h1;
            nxt_tbl_idx  = tbl_idx_ff + 16'h1;
            nxt_nbuf     = nbuf_ff + 16'h1;
            nxt_state    = S_ISSUE;
          end
        end else if (!v_offered) begin
          // A hole inside a list means the head was offered too early
          if (nbuf_ff != 16'h0) begin
            err_set   = 1'b1;
            nxt_state = S_HALT;
          end else begin
            nxt_state = S_IDLE; // Not yet offered: leave it alone
          end
        end else begin
          // Step to the next slot, toggling the wrap at the ring end
          nxt_pos  = last_slot ? 15'h0 : pos_ff + 15'h1;
          nxt_wrap = last_slot ? !wrap_ff : wrap_ff;
          nxt_id   = v_id;
          if (v_ind) begin
            if (nbuf_ff != 16'h0 || v_len[31:DESC_SHIFT] == 28'h0) begin
              err_set   = 1'b1;
              nxt_state = S_HALT;
            end else begin
              nxt_in_tbl   = 1'b1;
              nxt_tbl_base = v_addr;
              nxt_tbl_idx  = 16'h0;
              nxt_tbl_left = v_len[19:DESC_SHIFT];
              nxt_state    = S_TBL_RD;
            end
          end else if (nbuf_ff >= limit) begin
            err_set   = 1'b1;   // List longer than the cap
            nxt_state = S_HALT;
          end else begin
            nxt_buf_addr = v_addr;
            nxt_buf_len  = v_len;
            nxt_buf_wr   = v_wr;
            nxt_more     = v_chain;
            nxt_nbuf     = nbuf_ff + 16'h1;
            nxt_state    = S_ISSUE;
          end
        end
      end
      S_ISSUE: begin
        if (buf_ready) begin
          nxt_any_wr = any_wr_ff || buf_wr_ff;
          // Chained entries follow in ring order, table entries in table order
          if (more_ff) nxt_state = in_tbl_ff ? S_TBL_RD : S_RING_RD;
          else         nxt_state = S_WAIT_CMP;
        end
      end
      S_WAIT_CMP: begin
        if (cmp_valid) begin
          // Nothing was written if the list held no writable buffer
          nxt_used_len = any_wr_ff ? cmp_len : 32'h0;
          nxt_state    = S_WB;
        end
      end
      S_WB: begin
        if (mem_ack) nxt_state = S_EVT_RD;
      end
      S_EVT_RD: begin
        if (mem_ack) begin
          nxt_notify = notify_hit;
          count_inc  = 1'b1;
          nxt_head   = pos_ff;     // Next used entry lands at the next list head
          nxt_uwrap  = wrap_ff;
          nxt_in_tbl = 1'b0;
          nxt_nbuf   = 16'h0;
          nxt_any_wr = 1'b0;
          nxt_state  = S_IDLE;
        end
      end
      default: nxt_state = S_HALT; // Stuck until a queue reset
    endcase
  end

  // Walker registers; a queue reset restarts the ring at slot 0 with wrap 1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= S_IDLE;
      pos_ff   <= 15'h0;
      wrap_ff  <= WRAP_RST;
      head_ff  <= 15'h0;
      uwrap_ff <= WRAP_RST;
      nbuf_ff  <= 16'h0;
      in_tbl_ff <= 1'b0;
      any_wr_ff <= 1'b0;
    end else if (qrst) begin
      state_ff <= S_IDLE;
      pos_ff   <= 15'h0;
      wrap_ff  <= WRAP_RST;
      head_ff  <= 15'h0;
      uwrap_ff <= WRAP_RST;
      nbuf_ff  <= 16'h0;
      in_tbl_ff <= 1'b0;
      any_wr_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pos_ff   <= nxt_pos;
      wrap_ff  <= nxt_wrap;
      head_ff  <= nxt_head;
      uwrap_ff <= nxt_uwrap;
      nbuf_ff  <= nxt_nbuf;
      in_tbl_ff <= nxt_in_tbl;
      any_wr_ff <= nxt_any_wr;
    end
  end

  // Datapath registers carry no control meaning, so they skip the queue reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      raw_ff      <= 128'h0;
      tbl_base_ff <= 64'h0;
      tbl_idx_ff  <= 16'h0;
      tbl_left_ff <= 16'h0;
      id_ff       <= 16'h0;
      buf_addr_ff <= 64'h0;
      buf_len_ff  <= 32'h0;
      buf_wr_ff   <= 1'b0;
      more_ff     <= 1'b0;
      used_len_ff <= 32'h0;
      notify_ff   <= 1'b0;
    end else begin
      if (rd_done) raw_ff <= mem_rdata;
      tbl_base_ff <= nxt_tbl_base;
      tbl_idx_ff  <= nxt_tbl_idx;
      tbl_left_ff <= nxt_tbl_left;
      id_ff       <= nxt_id;
      buf_addr_ff <= nxt_buf_addr;
      buf_len_ff  <= nxt_buf_len;
      buf_wr_ff   <= nxt_buf_wr;
      more_ff     <= nxt_more;
      used_len_ff <= nxt_used_len;
      notify_ff   <= nxt_notify;
    end
  end

  // Sticky error and completed-list count; a new error wins over its clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_ff   <= 1'b0;
      count_ff <= 32'h0;
    end else begin
      if (err_set)      err_ff <= 1'b1;
      else if (err_clr) err_ff <= 1'b0;
      if (count_inc)    count_ff <= count_ff + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_fetch_in_order: assert property (state_ff == S_CHECK && !in_tbl_ff && v_offered && !qrst |=>
    pos_ff == (($past(pos_ff) == qsize_ff - 15'h1) ? 15'h0 : $past(pos_ff) + 15'h1))
    else $error("ring position did not advance by one slot");
  a_wb_at_head: assert property (state_ff == S_WB |-> mem_addr == ring_addr(ring_base_ff, head_ff))
    else $error("used entry written away from list head");
  a_ring_aligned: assert property (state_ff == S_RING_RD |-> mem_addr[3:0] == 4'h0)
    else $error("ring fetch not 16-byte aligned");
  a_unoffered_idle: assert property (state_ff == S_CHECK && !in_tbl_ff && !v_offered && !qrst |=>
    state_ff == S_IDLE || state_ff == S_HALT)
    else $error("unoffered entry was consumed");
  a_wb_phase_bits: assert property (mem_we |-> mem_wdata[127:112] == (uwrap_ff ? 16'h8080 : 16'h0000))
    else $error("used flags do not match used wrap");
  a_wb_single: assert property (state_ff == S_WB && mem_ack && !qrst |=> (state_ff != S_WB)[*2])
    else $error("used entry written twice");
  a_chain_cap: assert property (state_ff == S_ISSUE |-> nbuf_ff <= limit && nbuf_ff != 16'h0)
    else $error("list exceeds buffer cap");
  a_notify_off: assert property (state_ff == S_EVT_RD && mem_ack && evt_word[17:16] == EVT_DISABLE |=>
    !used_notify)
    else $error("notification sent while disabled");
  a_readonly_len: assert property (state_ff == S_WAIT_CMP && cmp_valid && !any_wr_ff && !qrst |=>
    state_ff == S_WB && used_len_ff == 32'h0)
    else $error("written length reported for read-only list");
  a_reset_wrap: assert property (qrst |=> wrap_ff && uwrap_ff && pos_ff == 15'h0)
    else $error("wrap counters not restarted at 1");

  c_indirect: cover property (state_ff == S_TBL_RD && mem_ack);
  c_chained: cover property (state_ff == S_ISSUE && buf_ready && more_ff && !in_tbl_ff);
  c_notify: cover property (used_notify);
  c_wrap: cover property (state_ff == S_CHECK && v_offered && last_slot && !in_tbl_ff);

endmodule // pqe_engine

// [pqe_mem_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Shared memory on the driver side: ring, buffers, suppression words
// ----------------------------------------------------------------
module pqe_mem_model (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         slow,
  input  wire logic         mem_req,
  input  wire logic         mem_we,
  input  wire logic [63:0]  mem_addr,
  input  wire logic [127:0] mem_wdata,
  output logic              mem_ack,
  output logic      [127:0] mem_rdata
);
  logic [127:0] mem [0:63];  // One 16-byte line per ring entry
  logic [1:0]   wait_ff;
  logic [127:0] last_ff;

  // Prompt or three-cycle answers; idle data lines never repeat the last read
  assign mem_ack   = mem_req && (wait_ff == (slow ? 2'h3 : 2'h0));
  assign mem_rdata = mem_ack ? mem[mem_addr[9:4]] : ~last_ff;

  // Ring is zero before use
  initial for (int i = 0; i < 64; i++) mem[i] = 128'h0;

  // Wait counter, last data seen, write-back into the line
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_ff <= 2'h0;
      last_ff <= 128'h0;
    end else begin
      wait_ff <= (mem_req && !mem_ack) ? wait_ff + 2'h1 : 2'h0;
      if (mem_ack) last_ff <= mem_rdata;
      if (mem_ack && mem_we) mem[mem_addr[9:4]] <= mem_wdata;
    end
  end
endmodule // pqe_mem_model

// [pqe_pkg.sv]
// ----------------------------------------------------------------
// Shared constants for the packed ring queue engine
// ----------------------------------------------------------------
package pqe_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_QSIZE   = 8'h04;
  localparam logic [7:0] OFF_RING_LO = 8'h08;
  localparam logic [7:0] OFF_RING_HI = 8'h0c;
  localparam logic [7:0] OFF_DEVT_LO = 8'h10;
  localparam logic [7:0] OFF_DEVT_HI = 8'h14;
  localparam logic [7:0] OFF_MAXCH   = 8'h18;
  localparam logic [7:0] OFF_NOTIFY  = 8'h1c;
  localparam logic [7:0] OFF_STATUS  = 8'h20;
  localparam logic [7:0] OFF_COUNT   = 8'h24;

  // Control and status bit positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_QRST_BIT = 1;
  localparam int ST_BUSY_BIT   = 16;
  localparam int ST_ERR_BIT    = 17;
  localparam int ST_UWRAP_BIT  = 18;

  // Values after reset
  localparam logic [14:0] QSIZE_RST = 15'h0100;
  localparam logic [15:0] MAXCH_RST = 16'h0000;
  localparam logic        WRAP_RST  = 1'b1;

  // Ring geometry: 16-byte entries, 4-byte suppression words
  localparam int DESC_SHIFT = 4;
  localparam int EVT_SHIFT  = 2;

  // Descriptor flag values
  localparam logic [15:0] F_CHAIN    = 16'h0001;
  localparam logic [15:0] F_WRITABLE = 16'h0002;
  localparam logic [15:0] F_INDIRECT = 16'h0004;
  localparam logic [15:0] F_OFFERED  = 16'h0080;
  localparam logic [15:0] F_CONSUMED = 16'h8000;

  // Notification policy codes
  localparam logic [1:0] EVT_ENABLE  = 2'h0;
  localparam logic [1:0] EVT_DISABLE = 2'h1;
  localparam logic [1:0] EVT_DESC    = 2'h2;

  typedef enum logic [3:0] {
    S_IDLE, S_RING_RD, S_TBL_RD, S_CHECK, S_ISSUE,
    S_WAIT_CMP, S_WB, S_EVT_RD, S_HALT
  } pqe_state_e;

endpackage

// [test_packed_ring_queue_engine.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Ring walk, chained list, wrap phases and queue reset over APB
// ----------------------------------------------------------------
module test_packed_ring_queue_engine import pqe_pkg::*;;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, slow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, buf_len, cmp_len;
  logic mem_req, mem_we, mem_ack, buf_valid, buf_ready, buf_writable, buf_last;
  logic cmp_valid, cmp_ready, used_notify;
  logic [63:0] mem_addr, buf_addr;
  logic [127:0] mem_wdata, mem_rdata;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;

  pqe_engine dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .buf_valid(buf_valid), .buf_ready(buf_ready), .buf_addr(buf_addr),
    .buf_len(buf_len), .buf_writable(buf_writable), .buf_last(buf_last), .cmp_valid(cmp_valid),
    .cmp_ready(cmp_ready), .cmp_len(cmp_len), .used_notify(used_notify));
  pqe_mem_model mdl (.clk(clk), .rst(rst), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #12.5 clk = ~clk;

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [127:0] line(logic [63:0] a, logic [31:0] l, logic [15:0] i, logic [15:0] f);
    return {f, i, l, a};
  endfunction

  // One APB transfer: setup, access held until pready at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                    input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, {e, r & m}, {xe, x});
  endtask

  // Accept one buffer after checking where it points, its size and how it may be used
  // Lets an edge pass first, so a back-to-back call never sees the buffer just accepted
  task automatic take(input logic [63:0] a, input logic [31:0] ln, input logic l, input logic w);
    int n;
    n = 0;
    @(posedge clk);
    while (buf_valid !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("buffer", {buf_addr, buf_len, buf_last, buf_writable}, {a, ln, l, w});
    buf_ready <= 1'b1;
    @(posedge clk);
    buf_ready <= 1'b0;
  endtask

  // Complete the list, then count notification pulses in a fixed window
  task automatic done(input logic [31:0] len, input int exp_n);
    int n, k;
    n = 0;
    k = 0;
    while (cmp_ready !== 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
    cmp_valid <= 1'b1;
    cmp_len <= len;
    @(posedge clk);
    cmp_valid <= 1'b0;
    repeat (60) begin
      @(posedge clk);
      if (used_notify === 1'b1) n++;
    end
    chk("notify", n, exp_n);
  endtask

  initial begin
    clk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    buf_ready = 1'b0; cmp_valid = 1'b0; cmp_len = 32'h0; slow = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd("qsize", OFF_QSIZE, 32'h7fff, 32'h0100, 1'b0);
    rd("status", OFF_STATUS, 32'h4ffff, 32'h48000, 1'b0);
    rd("unmapped", 8'h40, 32'hffffffff, 32'h0, 1'b1);
    wr(OFF_QSIZE, 32'h2);
    wr(OFF_RING_LO, 32'h0);
    wr(OFF_RING_HI, 32'h0);
    wr(OFF_DEVT_LO, 32'h200);
    wr(OFF_DEVT_HI, 32'h0);
    wr(OFF_MAXCH, 32'h0);
    wr(OFF_CTRL, 32'h1);
    repeat (30) @(posedge clk);
    chk("zero ring", buf_valid, 1'b0);
    // Two-entry list, tail first and head flags last, phase 1
    @(negedge clk);
    mdl.mem[32] = {96'h0, 14'h0, EVT_ENABLE, 16'h0};
    mdl.mem[1] = line(64'h2000, 32'h40, 16'h5, F_OFFERED | F_WRITABLE);
    mdl.mem[0] = line(64'h1000, 32'h10, 16'h0, F_OFFERED | F_CHAIN);
    take(64'h1000, 32'h10, 1'b0, 1'b0);
    take(64'h2000, 32'h40, 1'b1, 1'b1);
    done(32'h8, 1);
    chk("used", mdl.mem[0], line(64'h0, 32'h8, 16'h5, F_OFFERED | F_CONSUMED));
    chk("tail", mdl.mem[1], line(64'h2000, 32'h40, 16'h5, F_OFFERED | F_WRITABLE));
    rd("status", OFF_STATUS, 32'h4ffff, 32'h0, 1'b0);
    rd("count", OFF_COUNT, 32'hffffffff, 32'h1, 1'b0);
    // Phase 0 offer, slow memory, notifications disabled
    slow <= 1'b1;
    @(negedge clk);
    mdl.mem[32] = {96'h0, 14'h0, EVT_DISABLE, 16'h0};
    mdl.mem[0] = line(64'h3000, 32'h20, 16'h9, F_CONSUMED | F_WRITABLE);
    take(64'h3000, 32'h20, 1'b1, 1'b1);
    done(32'h4, 0);
    chk("used", mdl.mem[0], line(64'h0, 32'h4, 16'h9, 16'h0));
    rd("status", OFF_STATUS, 32'h4ffff, 32'h1, 1'b0);
    wr(OFF_CTRL, 32'h3);
    rd("status", OFF_STATUS, 32'h4ffff, 32'h48000, 1'b0);
    // Read-only indirect table, event at the slot just used; then a zero-length table halts
    @(negedge clk);
    mdl.mem[32] = {96'h0, 14'h0, EVT_DESC, 1'b1, 15'h0};
    mdl.mem[48] = line(64'h4000, 32'h10, 16'h0, 16'h0);
    mdl.mem[49] = line(64'h5000, 32'h20, 16'h0, 16'h0);
    mdl.mem[1] = line(64'h0, 32'h0, 16'h0, F_OFFERED | F_INDIRECT);
    mdl.mem[0] = line(64'h300, 32'h20, 16'h7, F_OFFERED | F_INDIRECT);
    take(64'h4000, 32'h10, 1'b0, 1'b0);
    take(64'h5000, 32'h20, 1'b1, 1'b0);
    done(32'h30, 1);
    chk("used", mdl.mem[0], line(64'h0, 32'h0, 16'h7, F_OFFERED | F_CONSUMED));
    wr(OFF_NOTIFY, 32'h8001);
    rd("hint", OFF_NOTIFY, 32'hffff, 32'h8001, 1'b0);
    rd("halt", OFF_STATUS, 32'h7ffff, 32'h70000, 1'b0);
    wr(OFF_STATUS, 32'h20000);
    wr(OFF_CTRL, 32'h3);
    rd("status", OFF_STATUS, 32'h6ffff, 32'h48000, 1'b0);
    end_sim();
  end
endmodule // test_packed_ring_queue_engine
